// File: hw/sram_core.sv
// strobe, burst and data-pin logic of the flow-through sram
`timescale 1ns/1ps
`default_nettype none
module sram_core
    import sram_pkg::*;
(
    input  wire logic              CLK_SYS,
    input  wire logic              SYS_RST,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic              PROCESSOR_ADDR_STROBE_N,
    input  wire logic              CONTROLLER_ADDR_STROBE_N,
    input  wire logic              PRIMARY_CHIP_SELECT_N,
    input  wire logic              SECONDARY_CHIP_SELECT,
    input  wire logic              TERTIARY_CHIP_SELECT_N,
    input  wire logic              BURST_ADVANCE_N,
    input  wire logic              ALL_BYTES_WRITE_N,
    input  wire logic              BYTE_WRITE_ENABLE_N,
    input  wire logic [LANES-1:0]  BYTE_SELECT_N,
    input  wire logic              OUTPUT_ENABLE_N,
    input  wire logic              SLEEP_REQUEST,
    input  wire logic              BURST_ORDER_SEL,
    input  wire logic [DATA_W-1:0] DATA_IN,
    output logic      [DATA_W-1:0] DATA_OUT,
    output logic                   DATA_OE_N,
    input  wire logic [LANES-1:0]  PARITY_DATA_LINES_IN,
    output logic      [LANES-1:0]  PARITY_DATA_LINES_OUT,
    output logic                   PARITY_DATA_LINES_OE_N
);
    access_state_t     state;
    access_state_t     next_state;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] next_addr_q;
    logic              order;
    logic              next_order;

    logic               awake;
    logic               chip_ok;
    logic               proc_take;
    logic               ctrl_take;
    logic               load;
    logic               write_any;
    logic [LANES-1:0]   lane_we;
    logic               in_burst;
    logic               advance;
    logic [BURST_W-1:0] burst_bits;
    logic [ADDR_W-1:0]  burst_addr;
    write_req_t         wr;

    // sleep freezes strobes, writes and stepping; store keeps its contents
    assign awake   = !SLEEP_REQUEST;
    assign chip_ok = !PRIMARY_CHIP_SELECT_N && SECONDARY_CHIP_SELECT
                     && !TERTIARY_CHIP_SELECT_N;

    assign proc_take = awake && !PROCESSOR_ADDR_STROBE_N
                       && !PRIMARY_CHIP_SELECT_N;
    assign ctrl_take = awake && !CONTROLLER_ADDR_STROBE_N
                       && PROCESSOR_ADDR_STROBE_N;
    assign load      = proc_take || ctrl_take;

    // global write overrides byte qualification
    assign lane_we   = {LANES{!ALL_BYTES_WRITE_N}}
                       | ({LANES{!BYTE_WRITE_ENABLE_N}} & ~BYTE_SELECT_N);
    assign write_any = |lane_we;

    assign in_burst   = (state != ST_DESEL);
    assign advance    = awake && !load && in_burst && !BURST_ADVANCE_N;
    assign burst_addr = {addr_q[ADDR_W-1:BURST_W], burst_bits};

    always_comb begin
        wr         = '0;
        wr.data    = DATA_IN;
        wr.parity  = PARITY_DATA_LINES_IN;
        wr.lane_we = lane_we;
        if (ctrl_take && chip_ok && write_any) begin
            wr.en   = 1'b1;
            wr.addr = ADDR;
        end else if (awake && !load && in_burst && write_any) begin
            wr.en   = 1'b1;
            wr.addr = burst_addr;
        end else begin
            wr.en   = 1'b0;
            wr.addr = burst_addr;
        end
    end

    // processor-strobe loads ignore the write inputs in their first cycle
    always_comb begin
        next_state  = state;
        next_addr_q = addr_q;
        if (load) begin
            if (chip_ok) begin
                next_addr_q = ADDR;
                next_state  = (state == ST_DESEL) ? ST_FIRST : ST_ACTIVE;
            end else begin
                next_state = ST_DESEL;
            end
        end else if (awake && state == ST_FIRST) begin
            next_state = ST_ACTIVE;
        end
    end

    // strap sampled while reset is held, then frozen
    always_comb begin
        next_order = SYS_RST ? BURST_ORDER_SEL : order;
    end

    always_ff @(posedge CLK_SYS) begin
        order <= next_order;
        if (SYS_RST) begin
            state  <= ST_DESEL;
            addr_q <= ADDR_RST;
        end else begin
            state  <= next_state;
            addr_q <= next_addr_q;
        end
    end

    burst_counter u_burst (
        .clk        (CLK_SYS),
        .rst        (SYS_RST),
        .load       (load && chip_ok),
        .start      (ADDR[BURST_W-1:0]),
        .advance    (advance),
        .order      (order),
        .burst_bits (burst_bits)
    );

    lane_store u_store (
        .clk       (CLK_SYS),
        .wr        (wr),
        .rd_addr   (burst_addr),
        .rd_data   (DATA_OUT),
        .rd_parity (PARITY_DATA_LINES_OUT)
    );

    // drive only when enabled, selected, settled and not in a write phase
    assign DATA_OE_N = OUTPUT_ENABLE_N || SLEEP_REQUEST
                       || (state != ST_ACTIVE)
                       || wr.en;
    assign PARITY_DATA_LINES_OE_N = DATA_OE_N;
endmodule
`default_nettype wire

// File: shared/sram_pkg.sv
// constants and carrier types shared by the flow-through sram block
// Notes on behaviour
// - processor strobe low at a clock rise loads the presented address.
// - controller strobe low at a clock rise loads the presented address.
// - every address load also seeds the burst counter with address bits [1:0].
// - both strobes low together: only the processor strobe is acted upon.
// - processor strobe is ignored while the primary chip select is high.
// - byte write only when byte write enable is low at the clock rise.
// - sleep input high stops all activity while keeping stored contents.
// - sleep must be low for normal use; a floating sleep pin reads low.
// - incoming data is captured into the store on the rising clock edge.
// - outgoing data is the word addressed at the previous clock rise.
// - output enable low drives data and parity lines, high floats them.
// - lines float during write data, first clock after deselect, and deselect.
// - parity lines act as data lines; each written under its byte select.
// - burst order strap low is linear; high or floating is interleaved.
// - advance low during a burst steps the burst address at that edge.
// - global write low writes all bytes, ignoring selects and byte enable.
package sram_pkg;
    localparam int ADDR_W    = 6;
    localparam int MEM_DEPTH = 64;
    localparam int LANES     = 4;
    localparam int BYTE_W    = 8;
    localparam int DATA_W    = 32;
    localparam int BURST_W   = 2;

    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 6'h00;
    localparam logic               MODE_LINEAR      = 1'b0;
    localparam logic               MODE_INTERLEAVED = 1'b1;
    localparam logic               MODE_RST         = MODE_INTERLEAVED;

    typedef enum logic [2:0] {
        ST_DESEL  = 3'h1,
        ST_FIRST  = 3'h2,
        ST_ACTIVE = 3'h4
    } access_state_t;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_we;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0]  parity;
    } write_req_t;
endpackage

// File: hw/burst_counter.sv
// two-bit wrapping burst counter with linear or interleaved order
`timescale 1ns/1ps
`default_nettype none
module burst_counter
    import sram_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               load,
    input  wire logic [BURST_W-1:0] start,
    input  wire logic               advance,
    input  wire logic               order,
    output logic      [BURST_W-1:0] burst_bits
);
    logic [BURST_W-1:0] start_q;
    logic [BURST_W-1:0] step;
    logic [BURST_W-1:0] next_start_q;
    logic [BURST_W-1:0] next_step;

    always_comb begin
        next_start_q = start_q;
        next_step    = step;
        if (load) begin
            next_start_q = start;
            next_step    = BURST_RST;
        end else if (advance) begin
            next_step = BURST_W'(step + BURST_ONE);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            start_q <= BURST_RST;
            step    <= BURST_RST;
        end else begin
            start_q <= next_start_q;
            step    <= next_step;
        end
    end

    // linear adds, interleaved xors; both wrap modulo four
    assign burst_bits = (order == MODE_LINEAR)
                        ? BURST_W'(start_q + step)
                        : start_q ^ step;
endmodule
`default_nettype wire

// File: hw/lane_store.sv
// flip-flop storage array with per-byte write lanes and parity
`timescale 1ns/1ps
`default_nettype none
module lane_store
    import sram_pkg::*;
(
    input  wire logic              clk,
    input  wire write_req_t        wr,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data,
    output logic      [LANES-1:0]  rd_parity
);
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [BYTE_W-1:0] mem_byte [MEM_DEPTH];
            logic              mem_par  [MEM_DEPTH];
            logic [BYTE_W-1:0] next_mem_byte [MEM_DEPTH];
            logic              next_mem_par  [MEM_DEPTH];

            always_comb begin
                next_mem_byte = mem_byte;
                next_mem_par  = mem_par;
                if (wr.en && wr.lane_we[g]) begin
                    next_mem_byte[wr.addr] = wr.data[g*BYTE_W +: BYTE_W];
                    next_mem_par[wr.addr]  = wr.parity[g];
                end
            end

            always_ff @(posedge clk) begin
                mem_byte <= next_mem_byte;
                mem_par  <= next_mem_par;
            end

            assign rd_data[g*BYTE_W +: BYTE_W] = mem_byte[rd_addr];
            assign rd_parity[g]                = mem_par[rd_addr];
        end
    endgenerate
endmodule
`default_nettype wire

// File: testbench/sram_core_sva.sv
// checker for strobe, select and data-pin timing of the sram core
`timescale 1ns/1ps
`default_nettype none
module sram_core_sva
    import sram_pkg::*;
(
    input wire logic              CLK_SYS,
    input wire logic              SYS_RST,
    input wire logic              PROCESSOR_ADDR_STROBE_N,
    input wire logic              CONTROLLER_ADDR_STROBE_N,
    input wire logic              PRIMARY_CHIP_SELECT_N,
    input wire logic              SECONDARY_CHIP_SELECT,
    input wire logic              TERTIARY_CHIP_SELECT_N,
    input wire logic              ALL_BYTES_WRITE_N,
    input wire logic              BYTE_WRITE_ENABLE_N,
    input wire logic              OUTPUT_ENABLE_N,
    input wire logic              SLEEP_REQUEST,
    input wire logic [DATA_W-1:0] DATA_IN,
    input wire logic [DATA_W-1:0] DATA_OUT,
    input wire logic              DATA_OE_N,
    input wire logic [LANES-1:0]  PARITY_DATA_LINES_IN,
    input wire logic [LANES-1:0]  PARITY_DATA_LINES_OUT,
    input wire logic              PARITY_DATA_LINES_OE_N
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    wire lp = !PROCESSOR_ADDR_STROBE_N && !PRIMARY_CHIP_SELECT_N;
    wire lc = !CONTROLLER_ADDR_STROBE_N && PROCESSOR_ADDR_STROBE_N;
    wire ld = (lp || lc) && !SLEEP_REQUEST;
    wire sel = !PRIMARY_CHIP_SELECT_N && SECONDARY_CHIP_SELECT
               && !TERTIARY_CHIP_SELECT_N;
    wire quiet = PROCESSOR_ADDR_STROBE_N && CONTROLLER_ADDR_STROBE_N
                 && ALL_BYTES_WRITE_N && BYTE_WRITE_ENABLE_N
                 && !OUTPUT_ENABLE_N && !SLEEP_REQUEST;

    a_oe_high_float: assert property (OUTPUT_ENABLE_N |-> DATA_OE_N)
        else $error("data driven while output enable high");
    a_parity_oe_same: assert property (PARITY_DATA_LINES_OE_N == DATA_OE_N)
        else $error("parity enable differs from data enable");
    a_sleep_floats: assert property (SLEEP_REQUEST |-> DATA_OE_N)
        else $error("data driven during sleep");
    a_deselect_float: assert property (ld && !sel |=> DATA_OE_N)
        else $error("data driven after deselect");
    a_first_clk_mask: assert property ((ld && !sel) ##1 (ld && sel) |=> DATA_OE_N)
        else $error("data driven in first clock after deselect");
    a_write_float: assert property (!ALL_BYTES_WRITE_N && PROCESSOR_ADDR_STROBE_N
        && (CONTROLLER_ADDR_STROBE_N || sel) |-> DATA_OE_N)
        else $error("data driven during write");
    a_write_readback: assert property (lc && sel && !SLEEP_REQUEST
        && !ALL_BYTES_WRITE_N ##1 !SLEEP_REQUEST |-> {DATA_OUT,
        PARITY_DATA_LINES_OUT} == $past({DATA_IN, PARITY_DATA_LINES_IN}))
        else $error("written word not read back");
    a_read_drives: assert property (ld && sel ##1 quiet ##1 quiet |-> !DATA_OE_N)
        else $error("read data not driven");
    c_proc_load: cover property (lp && sel && !SLEEP_REQUEST);
    c_ctrl_write: cover property (lc && sel && !ALL_BYTES_WRITE_N);
    c_sleep_wake: cover property (SLEEP_REQUEST ##1 !SLEEP_REQUEST);
endmodule
`default_nettype wire

// File: testbench/sram_pin_pulls.sv
// bus partner pins: sleep pulled down, burst order strap pulled up
`timescale 1ns/1ps
`default_nettype none
module sram_pin_pulls (
    input  wire logic sleep_en,
    input  wire logic sleep_val,
    input  wire logic mode_en,
    input  wire logic mode_val,
    output logic      sleep_pin,
    output logic      mode_pin
);
    assign sleep_pin = sleep_en ? sleep_val : 1'b0;
    assign mode_pin  = mode_en ? mode_val : 1'b1;
endmodule
`default_nettype wire

// File: testbench/sync_sram_strobe_and_data_io_tb_top.sv
// testbench top for the flow-through sram core
`timescale 1ns/1ps
`default_nettype none
module sync_sram_strobe_and_data_io_tb_top
    import sram_pkg::*;
;
    logic CLK_SYS, SYS_RST, PROCESSOR_ADDR_STROBE_N, CONTROLLER_ADDR_STROBE_N;
    logic PRIMARY_CHIP_SELECT_N, SECONDARY_CHIP_SELECT, TERTIARY_CHIP_SELECT_N;
    logic BURST_ADVANCE_N, ALL_BYTES_WRITE_N, BYTE_WRITE_ENABLE_N, DATA_OE_N;
    logic OUTPUT_ENABLE_N, SLEEP_REQUEST, BURST_ORDER_SEL;
    logic PARITY_DATA_LINES_OE_N, sleep_en, sleep_val, mode_en, mode_val;
    logic [ADDR_W-1:0] ADDR;
    logic [LANES-1:0]  BYTE_SELECT_N, PARITY_DATA_LINES_IN;
    logic [LANES-1:0]  PARITY_DATA_LINES_OUT;
    logic [DATA_W-1:0] DATA_IN, DATA_OUT;
    wire  [35:0]       q = {PARITY_DATA_LINES_OUT, DATA_OUT};
    int                num_errors, samples_checked, cycles, i;
    sram_core dut_u(.CLK_SYS, .SYS_RST, .ADDR, .PROCESSOR_ADDR_STROBE_N,
        .CONTROLLER_ADDR_STROBE_N, .PRIMARY_CHIP_SELECT_N,
        .SECONDARY_CHIP_SELECT, .TERTIARY_CHIP_SELECT_N, .BURST_ADVANCE_N,
        .ALL_BYTES_WRITE_N, .BYTE_WRITE_ENABLE_N, .BYTE_SELECT_N,
        .OUTPUT_ENABLE_N, .SLEEP_REQUEST, .BURST_ORDER_SEL, .DATA_IN,
        .DATA_OUT, .DATA_OE_N, .PARITY_DATA_LINES_IN, .PARITY_DATA_LINES_OUT,
        .PARITY_DATA_LINES_OE_N);
    sram_pin_pulls pull_u(.sleep_en, .sleep_val, .mode_en, .mode_val,
        .sleep_pin(SLEEP_REQUEST), .mode_pin(BURST_ORDER_SEL));
    function automatic logic [35:0] w(input logic [5:0] a);
        return {a[3:0], {4{2'b10, a}}};
    endfunction
    task chk(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task cyc(); @(posedge CLK_SYS); #2; endtask
    task ld(input logic p, input logic [5:0] a, input logic g);
        ADDR = a;
        PROCESSOR_ADDR_STROBE_N = !p;
        CONTROLLER_ADDR_STROBE_N = p;
        ALL_BYTES_WRITE_N = g;
        cyc();
    endtask
    task rel();
        PROCESSOR_ADDR_STROBE_N = 1;
        CONTROLLER_ADDR_STROBE_N = 1;
        ALL_BYTES_WRITE_N = 1;
    endtask
    task wr(input logic [5:0] a);
        {PARITY_DATA_LINES_IN, DATA_IN} = w(a);
        ld(0, a, 0);
    endtask
    task rst(input logic m);
        mode_en = 1; mode_val = m; SYS_RST = 1;
        repeat (2) cyc();
        SYS_RST = 0; mode_en = !m;
    endtask
    task t_write_read();
        wr(5); rel(); cyc(); chk(q, w(5));
        wr(6); ld(0, 5, 1); rel(); chk(q, w(5));
        cyc(); chk(DATA_OE_N, 0);
        OUTPUT_ENABLE_N = 1; #1 chk(DATA_OE_N, 1);
        cyc();
        OUTPUT_ENABLE_N = 0;
        $display("write read done");
    endtask
    task t_byte();
        logic [35:0] e;
        e = w(32); e[32] = 0; e[7:0] = 8'h55;
        wr(32); ld(1, 32, 1); rel();
        BYTE_WRITE_ENABLE_N = 0; BYTE_SELECT_N = 4'hE;
        {PARITY_DATA_LINES_IN, DATA_IN} = 36'h0_AAAA_AA55;
        #1 chk(DATA_OE_N, 1);
        cyc(); BYTE_WRITE_ENABLE_N = 1; chk(q, e);
        DATA_IN = 0; cyc(); chk(q, e);
        BYTE_SELECT_N = 4'hF; $display("byte write done");
    endtask
    task t_burst(input logic m);
        rst(m);
        for (i = 0; i < 4; i++) wr(6'(16 + i));
        ld(0, 17, 1); rel(); BURST_ADVANCE_N = 0;
        for (i = 0; i < 4; i++) begin
            chk(q, w(6'(16 + (m ? (1 ^ i) : ((1 + i) & 3)))));
            cyc();
        end
        BURST_ADVANCE_N = 1; $display("burst done");
    endtask
    task t_prio();
        SECONDARY_CHIP_SELECT = 0; ld(0, 19, 1);
        SECONDARY_CHIP_SELECT = 1; chk(DATA_OE_N, 1);
        ld(0, 16, 1); chk(DATA_OE_N, 1); chk(q, w(16));
        PRIMARY_CHIP_SELECT_N = 1; PROCESSOR_ADDR_STROBE_N = 0; ADDR = 19;
        cyc(); PRIMARY_CHIP_SELECT_N = 0; rel(); chk(q, w(16));
        chk(DATA_OE_N, 0);
        sleep_en = 1; sleep_val = 1; #1 chk(DATA_OE_N, 1);
        cyc();
        ld(0, 18, 1); rel(); sleep_en = 0; cyc(); chk(q, w(16));
        chk(DATA_OE_N, 0);
        // both strobes low with a global write: processor load, no write
        DATA_IN = 0;
        PARITY_DATA_LINES_IN = 0;
        ALL_BYTES_WRITE_N = 0;
        CONTROLLER_ADDR_STROBE_N = 0;
        PROCESSOR_ADDR_STROBE_N = 0;
        ADDR = 18;
        cyc();
        rel();
        chk(q, w(18));
        chk(DATA_OE_N, 0);
        $display("strobe priority done");
    endtask
    initial begin
        CLK_SYS = 0;
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        ADDR = 0; DATA_IN = 0; PARITY_DATA_LINES_IN = 0; BYTE_SELECT_N = 4'hF;
        PRIMARY_CHIP_SELECT_N = 0; SECONDARY_CHIP_SELECT = 1;
        TERTIARY_CHIP_SELECT_N = 0; BURST_ADVANCE_N = 1; OUTPUT_ENABLE_N = 0;
        BYTE_WRITE_ENABLE_N = 1; sleep_en = 0; sleep_val = 0; rel();
        rst(1); t_write_read(); t_byte(); t_burst(0); t_burst(1); t_prio();
        end_sim();
    end
endmodule
bind sram_core sram_core_sva chk_u(.CLK_SYS, .SYS_RST, .PROCESSOR_ADDR_STROBE_N,
    .CONTROLLER_ADDR_STROBE_N, .PRIMARY_CHIP_SELECT_N, .SECONDARY_CHIP_SELECT,
    .TERTIARY_CHIP_SELECT_N, .ALL_BYTES_WRITE_N, .BYTE_WRITE_ENABLE_N,
    .OUTPUT_ENABLE_N, .SLEEP_REQUEST, .DATA_IN, .DATA_OUT, .DATA_OE_N,
    .PARITY_DATA_LINES_IN, .PARITY_DATA_LINES_OUT, .PARITY_DATA_LINES_OE_N);
`default_nettype wire
